// [design/link_regs_defs.vh]
// Summary of operation
// - Control bits 15:8 reserved, read zero.
// - extended_sync lengthens FTS, adds TS2 leaving L1.
// - common_clock_cfg read-write, resets to zero.
// - common_clock_cfg selects reported exit latencies.
// - retrain_request and link_off_request read zero.
// - completion_boundary_hint writable, no behavioural effect.
// - Control bit 2 reserved, reads zero.
// - active_pm_control enables L0s, L1, or both.
// - Status bits 15:13 reserved, read zero.
// - slot_clock_cfg shows common 100-MHz reference clock.
// - training_flag and retrain_flag_status read zero.
// - negotiated_width constantly reads single lane.
// - link_speed_field constantly reads 2.5 Gb/s.
`ifndef LINK_REGS_DEFS_VH
`define LINK_REGS_DEFS_VH
`define SERIAL_LINK_CONTROL_OFF 8'ha0
`define SERIAL_LINK_STATUS_OFF 8'ha2
`define CTRL_RESET 16'h0000
`define CTRL_WRITABLE_MASK 16'h00cb
`define CTRL_EXT_SYNC_BIT 7
`define CTRL_COMMON_CLK_BIT 6
`define CTRL_HINT_BIT 3
`define CTRL_ASPM_LSB 0
`define CTRL_EXT_SYNC_RESET 1'h0
`define CTRL_COMMON_CLK_RESET 1'h0
`define CTRL_HINT_RESET 1'h0
`define CTRL_ASPM_RESET 2'h0
`define STAT_SLOT_CLK_BIT 12
`define STAT_SLOT_CLK_RESET 1'h0
`define STAT_WIDTH_LSB 4
`define STAT_WIDTH_X1 6'h01
`define STAT_SPEED_LSB 0
`define STAT_SPEED_2G5 4'h1
`define RDATA_IDLE 16'h0000
`define ALLOW_RESET 1'h0
`define EXIT_LAT_RESET 3'h0
`define BASE_FTS_COUNT 8'h20
`define EXT_FTS_COUNT 8'hff
`endif

// [design/link_ctrl_decode.v]
`timescale 1ns/1ps
`default_nettype none
`include "link_regs_defs.vh"
module link_ctrl_decode (
    // Control value
    input wire [15:0] ctrl,
    // Latency candidates
    input wire [2:0] l0s_lat_common,
    input wire [2:0] l0s_lat_async,
    input wire [2:0] l1_lat_common,
    input wire [2:0] l1_lat_async,
    // Decoded settings
    output wire [7:0] fts_count,
    output wire extra_ts2,
    output wire l0s_allow,
    output wire l1_allow,
    output wire [2:0] l0s_lat,
    output wire [2:0] l1_lat
);
    assign fts_count = ctrl[`CTRL_EXT_SYNC_BIT] ? `EXT_FTS_COUNT : `BASE_FTS_COUNT;
    assign extra_ts2 = ctrl[`CTRL_EXT_SYNC_BIT];
    assign l0s_allow = ctrl[`CTRL_ASPM_LSB];
    assign l1_allow = ctrl[`CTRL_ASPM_LSB + 1];
    assign l0s_lat = ctrl[`CTRL_COMMON_CLK_BIT] ? l0s_lat_common : l0s_lat_async;
    assign l1_lat = ctrl[`CTRL_COMMON_CLK_BIT] ? l1_lat_common : l1_lat_async;
endmodule
`default_nettype wire

// [design/serial_link_ctrl_status_regs.v]
`timescale 1ns/1ps
`default_nettype none
`include "link_regs_defs.vh"
module serial_link_ctrl_status_regs (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // Configuration access
    input wire cfg_wr,
    input wire cfg_rd,
    input wire [7:0] cfg_addr,
    input wire [15:0] cfg_wdata,
    input wire [1:0] cfg_be,
    output reg [15:0] cfg_rdata,
    // Platform strap and latency inputs
    input wire slot_clock_common,
    input wire [2:0] l0s_lat_common,
    input wire [2:0] l0s_lat_async,
    input wire [2:0] l1_lat_common,
    input wire [2:0] l1_lat_async,
    // Settings to the link layer
    output reg [7:0] fts_count,
    output reg extra_ts2,
    output reg l0s_allow,
    output reg l1_allow,
    output reg [2:0] l0s_exit_lat,
    output reg [2:0] l1_exit_lat,
    output reg completion_boundary_hint
);
    // Only these fields hold state; every other control bit is wired to zero.
    reg extended_sync;
    reg common_clock_cfg;
    reg hint_field;
    reg [1:0] active_pm_control;
    reg slot_clk;
    reg next_extended_sync;
    reg next_common_clock_cfg;
    reg next_hint_field;
    reg [1:0] next_active_pm_control;
    reg [15:0] next_rdata;
    wire ctrl_hit;
    wire status_hit;
    wire ctrl_write;
    wire [15:0] ctrl;
    wire [15:0] status;
    wire [7:0] dec_fts;
    wire dec_ts2;
    wire dec_l0s;
    wire dec_l1;
    wire [2:0] dec_l0s_lat;
    wire [2:0] dec_l1_lat;

    // Address decode is shared by the write and the read paths.
    function addr_match;
        input [7:0] addr;
        input [7:0] offset;
        begin
            addr_match = (addr == offset);
        end
    endfunction

    // Byte enable that covers a given bit of the 16-bit word.
    function lane_of;
        input [1:0] be;
        input integer pos;
        begin
            if (pos < 8) begin
                lane_of = be[0];
            end else begin
                lane_of = be[1];
            end
        end
    endfunction

    // A writable bit takes the new value only when its byte lane is enabled.
    function merge_bit;
        input old_bit;
        input new_bit;
        input lane_en;
        begin
            if (lane_en) begin
                merge_bit = new_bit;
            end else begin
                merge_bit = old_bit;
            end
        end
    endfunction

    // Moves a field value to its bit position inside a register word.
    function [15:0] place_field;
        input [15:0] value;
        input integer pos;
        begin
            place_field = value << pos;
        end
    endfunction

    // Fixed bits are never stored, so no write can make them read as one.
    function [15:0] ctrl_word_of;
        input sync_bit;
        input clk_bit;
        input hint_bit;
        input [1:0] pm_bits;
        begin
            ctrl_word_of = place_field({15'h0, sync_bit}, `CTRL_EXT_SYNC_BIT)
                | place_field({15'h0, clk_bit}, `CTRL_COMMON_CLK_BIT)
                | place_field({15'h0, hint_bit}, `CTRL_HINT_BIT)
                | place_field({14'h0, pm_bits}, `CTRL_ASPM_LSB);
        end
    endfunction

    // Status word: only the strap bit varies; width and speed are fixed codes.
    function [15:0] status_word_of;
        input slot;
        begin
            status_word_of = place_field({15'h0, slot}, `STAT_SLOT_CLK_BIT)
                | place_field({10'h0, `STAT_WIDTH_X1}, `STAT_WIDTH_LSB)
                | place_field({12'h0, `STAT_SPEED_2G5}, `STAT_SPEED_LSB);
        end
    endfunction

    // Read data drops back to zero whenever no read is asked for.
    function [15:0] read_select;
        input rd;
        input hit_ctrl;
        input hit_status;
        input [15:0] ctrl_val;
        input [15:0] status_val;
        begin
            if (!rd) begin
                read_select = `RDATA_IDLE;
            end else if (hit_ctrl) begin
                read_select = ctrl_val;
            end else if (hit_status) begin
                read_select = status_val;
            end else begin
                read_select = `RDATA_IDLE;
            end
        end
    endfunction

    assign ctrl_hit = addr_match(cfg_addr, `SERIAL_LINK_CONTROL_OFF);
    assign status_hit = addr_match(cfg_addr, `SERIAL_LINK_STATUS_OFF);
    // Writes to the status offset or any other address fall through untouched.
    assign ctrl_write = cfg_wr && ctrl_hit;
    assign ctrl = ctrl_word_of(extended_sync, common_clock_cfg, hint_field, active_pm_control);
    assign status = status_word_of(slot_clk);

    always @* begin
        next_extended_sync = extended_sync;
        if (ctrl_write) begin
            next_extended_sync = merge_bit(extended_sync, cfg_wdata[`CTRL_EXT_SYNC_BIT],
                lane_of(cfg_be, `CTRL_EXT_SYNC_BIT));
        end
    end

    always @* begin
        next_common_clock_cfg = common_clock_cfg;
        if (ctrl_write) begin
            next_common_clock_cfg = merge_bit(common_clock_cfg, cfg_wdata[`CTRL_COMMON_CLK_BIT],
                lane_of(cfg_be, `CTRL_COMMON_CLK_BIT));
        end
    end

    always @* begin
        next_hint_field = hint_field;
        if (ctrl_write) begin
            next_hint_field = merge_bit(hint_field, cfg_wdata[`CTRL_HINT_BIT],
                lane_of(cfg_be, `CTRL_HINT_BIT));
        end
    end

    always @* begin
        next_active_pm_control = active_pm_control;
        if (ctrl_write) begin
            next_active_pm_control[0] = merge_bit(active_pm_control[0], cfg_wdata[`CTRL_ASPM_LSB],
                lane_of(cfg_be, `CTRL_ASPM_LSB));
            next_active_pm_control[1] = merge_bit(active_pm_control[1], cfg_wdata[`CTRL_ASPM_LSB + 1],
                lane_of(cfg_be, `CTRL_ASPM_LSB + 1));
        end
    end

    always @* begin
        next_rdata = read_select(cfg_rd, ctrl_hit, status_hit, ctrl, status);
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            extended_sync <= `CTRL_EXT_SYNC_RESET;
        end else begin
            extended_sync <= next_extended_sync;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            common_clock_cfg <= `CTRL_COMMON_CLK_RESET;
        end else begin
            common_clock_cfg <= next_common_clock_cfg;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hint_field <= `CTRL_HINT_RESET;
        end else begin
            hint_field <= next_hint_field;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            active_pm_control <= `CTRL_ASPM_RESET;
        end else begin
            active_pm_control <= next_active_pm_control;
        end
    end

    // The strap is taken on the clock, so status bit 12 trails it by one cycle.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            slot_clk <= `STAT_SLOT_CLK_RESET;
        end else begin
            slot_clk <= slot_clock_common;
        end
    end

    link_ctrl_decode u_dec (
        .ctrl(ctrl),
        .l0s_lat_common(l0s_lat_common),
        .l0s_lat_async(l0s_lat_async),
        .l1_lat_common(l1_lat_common),
        .l1_lat_async(l1_lat_async),
        .fts_count(dec_fts),
        .extra_ts2(dec_ts2),
        .l0s_allow(dec_l0s),
        .l1_allow(dec_l1),
        .l0s_lat(dec_l0s_lat),
        .l1_lat(dec_l1_lat)
    );

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rdata <= `RDATA_IDLE;
        end else begin
            cfg_rdata <= next_rdata;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            fts_count <= `BASE_FTS_COUNT;
        end else begin
            fts_count <= dec_fts;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            extra_ts2 <= `CTRL_EXT_SYNC_RESET;
        end else begin
            extra_ts2 <= dec_ts2;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            l0s_allow <= `ALLOW_RESET;
        end else begin
            l0s_allow <= dec_l0s;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            l1_allow <= `ALLOW_RESET;
        end else begin
            l1_allow <= dec_l1;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            l0s_exit_lat <= `EXIT_LAT_RESET;
        end else begin
            l0s_exit_lat <= dec_l0s_lat;
        end
    end

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            l1_exit_lat <= `EXIT_LAT_RESET;
        end else begin
            l1_exit_lat <= dec_l1_lat;
        end
    end

    // Informational only; the port's own boundary stays at 128 bytes.
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            completion_boundary_hint <= `CTRL_HINT_RESET;
        end else begin
            completion_boundary_hint <= hint_field;
        end
    end
endmodule
`default_nettype wire

// [testbench/link_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module link_partner (
    // Strap choice and platform outputs
    input wire logic strap_sel,
    output logic slot_clock_common,
    output logic [2:0] l0s_lat_common, l0s_lat_async, l1_lat_common, l1_lat_async
);
    // Candidates differ so that a swapped selection shows.
    assign slot_clock_common = strap_sel;
    assign l0s_lat_common = 3'h3;
    assign l0s_lat_async = 3'h4;
    assign l1_lat_common = 3'h2;
    assign l1_lat_async = 3'h5;
endmodule
`default_nettype wire

// [testbench/link_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module link_regs_chk (
    input wire logic ref_clk, arst_n, cfg_wr, cfg_rd, slot_clock_common,
    input wire logic [7:0] cfg_addr, fts_count,
    input wire logic [15:0] cfg_wdata, cfg_rdata,
    input wire logic [1:0] cfg_be,
    input wire logic [2:0] l0s_lat_common, l0s_lat_async, l0s_exit_lat,
    input wire logic extra_ts2, l0s_allow, l1_allow, completion_boundary_hint
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_wr; cfg_wr && cfg_addr == 8'ha0 && cfg_be[0]; endsequence
    sequence s_rs; cfg_rd && cfg_addr == 8'ha2; endsequence
    AST_EXT_SYNC: assert property (s_wr |-> ##2 extra_ts2 == $past(cfg_wdata[7], 2)) else $error("sync bad");
    AST_FTS: assert property (fts_count == (extra_ts2 ? 8'hff : 8'h20)) else $error("fts bad");
    AST_LAT: assert property (s_wr |-> ##2 l0s_exit_lat == ($past(cfg_wdata[6], 2) ? l0s_lat_common
        : l0s_lat_async)) else $error("latency bad");
    AST_HINT: assert property (s_wr |-> ##2 completion_boundary_hint == $past(cfg_wdata[3], 2))
        else $error("hint bad");
    AST_ASPM: assert property (s_wr |-> ##2 {l1_allow, l0s_allow} == $past(cfg_wdata[1:0], 2))
        else $error("pm bad");
    AST_CTRL_FIXED: assert property (cfg_rd && cfg_addr == 8'ha0 |=> (cfg_rdata & 16'hff34) == 16'h0000)
        else $error("ctrl fixed bits bad");
    AST_STAT_FIXED: assert property (s_rs |=> (cfg_rdata & 16'hefff) == 16'h0011)
        else $error("status bad");
    AST_SLOT: assert property (s_rs ##0 $stable(slot_clock_common) |=> cfg_rdata[12] == $past(slot_clock_common))
        else $error("slot clock bad");
endmodule
bind serial_link_ctrl_status_regs link_regs_chk chk_u (.*);
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    logic ref_clk = 0, arst_n = 0, cfg_wr = 0, cfg_rd = 0, strap_sel = 1, slot_clock_common;
    logic [7:0] cfg_addr = 8'h00, fts_count;
    logic [15:0] cfg_wdata = 16'h0000, cfg_rdata;
    logic [1:0] cfg_be = 2'h0;
    logic [2:0] l0s_lat_common, l0s_lat_async, l1_lat_common, l1_lat_async, l0s_exit_lat, l1_exit_lat;
    logic extra_ts2, l0s_allow, l1_allow, completion_boundary_hint;
    int mismatches = 0, n_compared = 0;
    link_partner part_u (.*);
    serial_link_ctrl_status_regs dut_u (.*);
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
        @(posedge ref_clk);
        {cfg_wr, cfg_addr, cfg_wdata, cfg_be} <= {1'b1, a, d, b};
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        {cfg_rd, cfg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        cfg_rd <= 1'b0;
        #1;
        `CHK(cfg_rdata, e)
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        `CHK(fts_count, 8'h20)
        arst_n <= 1'b1;
        rd(8'ha0, 16'h0000);
        // Fixed bits are written as ones every time so a leak shows at once.
        for (int i = 0; i < 4; i++) begin
            wr(8'ha0, {8'hff, i[0], i[0], 2'b11, i[0], 1'b1, i[1:0]}, 2'h3);
            rd(8'ha0, {8'h00, i[0], i[0], 2'b00, i[0], 1'b0, i[1:0]});
            `CHK({fts_count, extra_ts2, l1_allow, l0s_allow, l0s_exit_lat, l1_exit_lat, completion_boundary_hint},
                {i[0] ? 8'hff : 8'h20, i[0], i[1:0], i[0] ? 6'o32 : 6'o45, i[0]})
        end
        wr(8'ha0, 16'h0000, 2'h2);
        rd(8'ha0, 16'h00cb);
        wr(8'ha2, 16'h0000, 2'h3);
        rd(8'ha2, 16'h1011);
        // A reset in mid-run must clear fields that were set, not only fresh ones.
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        `CHK({fts_count, extra_ts2, l1_allow, l0s_allow, l0s_exit_lat, l1_exit_lat, completion_boundary_hint},
            {8'h20, 10'h000})
        arst_n <= 1'b1;
        rd(8'ha0, 16'h0000);
        @(posedge ref_clk);
        strap_sel <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rd(8'ha2, 16'h0011);
        complete_run();
    end
endmodule
`default_nettype wire
